/* File: frr_defines.svh */
`ifndef FRR_DEFINES_SVH
`define FRR_DEFINES_SVH

// CRC generator, preset and good-frame residue
`define FRR_CRC_POLY 32'h04C11DB7
`define FRR_CRC_PRESET 32'hFFFFFFFF
`define FRR_CRC_RESIDUE 32'hC704DD7B
// CRC characters per frame, also the depth of the cut-through delay line
`define FRR_CRC_BYTES 3'h4

// Control character layout and codes
`define FRR_TYPE_HI 3
`define FRR_TYPE_LO 2
`define FRR_SUB_HI 1
`define FRR_TYPE_APP 2'h0
`define FRR_TYPE_RSV 2'h1
`define FRR_TYPE_PRIV 2'h2
`define FRR_TYPE_CTRL 2'h3
`define FRR_RST_LINK 2'h0
`define FRR_RST_RSV 2'h2

// Path and channel byte layout
`define FRR_EXT_BIT 7
`define FRR_IDX_HI 6
`define FRR_ADDR_LOCAL 8'h00
`define FRR_ADDR_BAD 8'h80
`define FRR_PATH_MAX 3'h4
`define FRR_CHAN_MAX 2'h2

// Field length limits; counter limit includes the four CRC characters
`define FRR_DATA_MAX 8'h80
`define FRR_CMSG_MAX 8'h20
`define FRR_CNT_LIMIT 8'h84
`define FRR_ALIGN_MASK 8'h07

`endif

/* File: frr_pkg.sv */
`default_nettype none
package frr_pkg;

  typedef enum logic [1:0] {
    FRR_K_DATA = 2'h0,
    FRR_K_FLAG = 2'h1,
    FRR_K_ABORT = 2'h2,
    FRR_K_SPECIAL = 2'h3
  } frr_kind_e;

  typedef struct packed {
    frr_kind_e kind;
    logic [7:0] data;
  } frr_char_s;

  typedef enum logic [2:0] {
    FRR_P_IDLE = 3'h0,
    FRR_P_STATUS = 3'h1,
    FRR_P_PATH = 3'h2,
    FRR_P_CHAN = 3'h3,
    FRR_P_DATA = 3'h4,
    FRR_P_DISCARD = 3'h5
  } frr_pst_e;

  typedef enum logic [2:0] {
    FRR_T_NONE = 3'h0,
    FRR_T_CRC0 = 3'h1,
    FRR_T_CRC1 = 3'h2,
    FRR_T_CRC2 = 3'h3,
    FRR_T_CRC3 = 3'h4,
    FRR_T_FLAG = 3'h5,
    FRR_T_ABORT = 3'h6,
    FRR_T_AFLAG = 3'h7
  } frr_tst_e;

  typedef enum logic [1:0] {
    FRR_ERP_NONE = 2'h0,
    FRR_ERP_CRC = 2'h1,
    FRR_ERP_REJECT = 2'h2
  } frr_erp_e;

  typedef struct packed {
    logic [1:0] frame_type;
    logic [1:0] sub_type;
    logic [7:0] status;
    logic [13:0] channel;
    logic ctl_msg;
    logic [7:0] data_len;
    logic len_aligned;
  } frr_hdr_s;

endpackage
`default_nettype wire

/* File: frr_crc32.sv */
`include "frr_defines.svh"
`default_nettype none
module frr_crc32
(
  input wire logic clk_sys, // Character clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic preset, // Load all ones
  input wire logic step, // Fold in one character
  input wire logic [7:0] din, // Character folded in
  output logic [31:0] crc // Running remainder
);
  import frr_pkg::*;

  // One character, most significant bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[31] ^ d[i])
        r = {r[30:0], 1'b0} ^ `FRR_CRC_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      crc <= `FRR_CRC_PRESET;
    else if (preset)
      crc <= `FRR_CRC_PRESET;
    else if (step)
      crc <= crc_byte(crc, din);
  end

endmodule
`default_nettype wire

/* File: frr_router.sv */
`include "frr_defines.svh"
`default_nettype none
// How it works
// - Link reset carries status; other resets carry path
// - Address field holds path then channel parts
// - Extend bit chains bytes; clear ends each part
// - Low seven bits are an unsigned hop index
// - Forwarding decrements the first path byte
// - Path up to four, channel up to two; longer paths are not rejected
// - Channel number from one or two bytes
// - Channel zero carries control messages
// - Data field follows the parsed address
// - Data field holds zero to 128 characters
// - Non-final data frames are multiples of eight; not rejected, only flagged in len_aligned
// - Control message data at most 32 bytes
// - Last four data characters are the CRC
// - Fields trusted only after the CRC checks
// - Forwarded frames get a freshly computed CRC
// - Degree 32 generator polynomial, modulo two
// - Preset ones, send complemented remainder
// - Wrong residue triggers link recovery, CRC code
// - Cut-through unless outbound busy or waiting
// - Five characters latency; FLAG before CRC out
// - Bad forwarded frame ends with ABORT then FLAG
// - Invalid path triggers link recovery, reject code
// - Control character type in bits three, two
module frr_router
(
  input wire logic clk_sys, // 20 MHz character clock
  input wire logic rstn, // Port reset, active low
  input wire logic in_valid, // Inbound character present
  input wire frr_pkg::frr_char_s in_char, // Inbound character
  output logic in_ready, // Inbound character taken when valid
  input wire logic out_busy, // Outbound port sending its own frame
  input wire logic ready_wait_flag, // Outbound port waiting for receiver ready
  output logic out_valid, // Outbound character present
  output frr_pkg::frr_char_s out_char, // Outbound character
  output logic loc_valid, // Local data character present
  output logic [7:0] loc_data, // Local data character
  output logic loc_ok, // Local frame good, header valid
  output frr_pkg::frr_hdr_s loc_hdr, // Local frame header
  output logic erp_req, // Link recovery request pulse
  output frr_pkg::frr_erp_e erp_code // Link recovery error code
);
  import frr_pkg::*;

  logic rst_sync_q;
  logic rst_n;
  frr_pst_e pst;
  frr_tst_e tst;
  frr_tst_e next_tst;
  logic [7:0] dl_data [4];
  logic [3:0] dl_tag;
  logic [2:0] dl_cnt;
  logic [2:0] next_cnt;
  logic fwd;
  logic local_acc;
  logic go;
  logic sent;
  logic rej;
  logic ovf;
  logic in_aborted;
  logic is_addr;
  logic path_first;
  logic [1:0] ftype;
  logic [1:0] sub;
  logic [7:0] status;
  logic [2:0] path_cnt;
  logic [1:0] chan_cnt;
  logic [6:0] chan_b [2];
  logic [7:0] data_cnt;
  logic [31:0] rx_crc;
  logic [31:0] tx_crc;
  logic acc;
  logic acc_data;
  logic acc_flag;
  logic acc_abort;
  logic blocked;
  logic push;
  logic pop;
  logic ovf_now;
  logic start_go;
  logic crc_good;
  logic end_frame;
  logic fwd_abort;
  logic short_frame;
  logic loc_reject;
  logic next_in_ready;
  logic next_out_valid;
  frr_char_s next_out_char;
  logic [7:0] push_byte;
  logic [7:0] data_len;
  logic [13:0] chan_num;
  logic [7:0] d;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_sync_q <= 1'b1;
      rst_n <= rst_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character decode
  assign d = in_char.data;
  assign acc = in_valid && in_ready;
  assign acc_data = acc && (in_char.kind == FRR_K_DATA);
  assign acc_flag = acc && (in_char.kind == FRR_K_FLAG);
  assign acc_abort = acc && (in_char.kind == FRR_K_ABORT);
  assign blocked = out_busy || ready_wait_flag;
  assign end_frame = acc_flag && (pst != FRR_P_IDLE);
  assign crc_good = (rx_crc == `FRR_CRC_RESIDUE);
  assign ovf_now = acc_data && (pst == FRR_P_DATA) && (data_cnt == `FRR_CNT_LIMIT);
  assign push = acc_data && (pst != FRR_P_DISCARD) && !ovf_now;
  assign pop = push && (dl_cnt == `FRR_CRC_BYTES);
  assign start_go = fwd && !go && (dl_cnt == `FRR_CRC_BYTES) && !blocked && (pst != FRR_P_DISCARD);
  assign fwd_abort = fwd && sent && (pst != FRR_P_DISCARD) &&
                     (acc_abort || ovf_now || (acc_flag && !crc_good));
  assign push_byte = (pst == FRR_P_PATH && path_first && d[`FRR_IDX_HI:0] != 7'h00) ?
                     {d[`FRR_EXT_BIT], d[`FRR_IDX_HI:0] - 7'h01} : d;
  assign data_len = data_cnt - 8'(`FRR_CRC_BYTES);
  assign chan_num = (chan_cnt == `FRR_CHAN_MAX) ? {chan_b[0], chan_b[1]} : {7'h00, chan_b[0]};
  assign short_frame = (pst != FRR_P_DATA) || (data_cnt < 8'(`FRR_CRC_BYTES));

  always_comb
  begin
    loc_reject = rej || ovf || short_frame || (ftype == `FRR_TYPE_RSV);
    if (ftype == `FRR_TYPE_CTRL)
      loc_reject = loc_reject || (sub == `FRR_RST_RSV) || (data_len != 8'h00);
    else
      loc_reject = loc_reject || (data_len > `FRR_DATA_MAX) ||
                   (chan_num == 14'h0000 && data_len > `FRR_CMSG_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field parser
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pst <= FRR_P_IDLE;
      chan_b[0] <= 7'h00;
      chan_b[1] <= 7'h00;
      ftype <= 2'h0;
      sub <= 2'h0;
      status <= 8'h00;
      is_addr <= 1'b0;
      path_first <= 1'b0;
      path_cnt <= 3'h0;
      chan_cnt <= 2'h0;
      data_cnt <= 8'h00;
      fwd <= 1'b0;
      local_acc <= 1'b0;
      rej <= 1'b0;
      ovf <= 1'b0;
      in_aborted <= 1'b0;
    end
    else if (acc_flag)
    begin
      pst <= FRR_P_IDLE;
      path_cnt <= 3'h0;
      chan_cnt <= 2'h0;
      data_cnt <= 8'h00;
      fwd <= 1'b0;
      local_acc <= 1'b0;
      rej <= 1'b0;
      ovf <= 1'b0;
      in_aborted <= 1'b0;
    end
    else if (acc_abort)
    begin
      pst <= FRR_P_DISCARD;
      in_aborted <= 1'b1;
    end
    else if (acc_data)
    begin
      case (pst)
        FRR_P_IDLE:
        begin
          ftype <= d[`FRR_TYPE_HI:`FRR_TYPE_LO];
          sub <= d[`FRR_SUB_HI:0];
          is_addr <= (d[`FRR_TYPE_HI:`FRR_TYPE_LO] != `FRR_TYPE_CTRL);
          path_first <= 1'b1;
          if (d[`FRR_TYPE_HI:`FRR_TYPE_LO] == `FRR_TYPE_CTRL && d[`FRR_SUB_HI:0] == `FRR_RST_LINK)
            pst <= FRR_P_STATUS;
          else
            pst <= FRR_P_PATH;
        end
        FRR_P_STATUS:
        begin
          status <= d;
          local_acc <= 1'b1;
          pst <= FRR_P_DATA;
        end
        FRR_P_PATH:
        begin
          path_first <= 1'b0;
          if (path_cnt != `FRR_PATH_MAX)
            path_cnt <= path_cnt + 3'h1;
          if (path_first)
          begin
            if (d == `FRR_ADDR_LOCAL)
              local_acc <= 1'b1;
            else if (d == `FRR_ADDR_BAD)
              rej <= 1'b1;
            else
              fwd <= 1'b1;
          end
          if (!d[`FRR_EXT_BIT])
            pst <= is_addr ? FRR_P_CHAN : FRR_P_DATA;
        end
        FRR_P_CHAN:
        begin
          if (chan_cnt != `FRR_CHAN_MAX)
            chan_cnt <= chan_cnt + 2'h1;
          if (chan_cnt == 2'h0)
          begin
            chan_b[0] <= d[`FRR_IDX_HI:0];
            if (d == `FRR_ADDR_BAD)
              rej <= 1'b1;
          end
          else
          begin
            chan_b[1] <= d[`FRR_IDX_HI:0];
            if (d[`FRR_EXT_BIT])
              rej <= 1'b1;
          end
          if (!d[`FRR_EXT_BIT] || chan_cnt != 2'h0)
            pst <= FRR_P_DATA;
        end
        FRR_P_DATA:
        begin
          if (ovf_now)
          begin
            ovf <= 1'b1;
            pst <= FRR_P_DISCARD;
          end
          else
            data_cnt <= data_cnt + 8'h01;
        end
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay line holding the last four data characters
  always_comb
  begin
    if (acc_flag || acc_abort || ovf_now)
      next_cnt = 3'h0;
    else if (push && dl_cnt != `FRR_CRC_BYTES)
      next_cnt = dl_cnt + 3'h1;
    else
      next_cnt = dl_cnt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dl_cnt <= 3'h0;
      dl_tag <= 4'h0;
    end
    else
    begin
      dl_cnt <= next_cnt;
      if (push)
        dl_tag <= {pst == FRR_P_DATA, dl_tag[3:1]};
    end
  end

  for (genvar i = 0; i < 3; i++)
  begin : g_slot
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        dl_data[i] <= 8'h00;
      else if (push)
        dl_data[i] <= dl_data[i + 1];
    end
  end

  // Reset keeps idle out_char and loc_data at zero instead of unknown
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dl_data[3] <= 8'h00;
    else if (push)
      dl_data[3] <= push_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cut-through forwarding and trailer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      go <= 1'b0;
      sent <= 1'b0;
    end
    else if (acc_flag || acc_abort || ovf_now)
    begin
      go <= 1'b0;
      sent <= 1'b0;
    end
    else
    begin
      if (start_go)
        go <= 1'b1;
      if (pop && go)
        sent <= 1'b1;
    end
  end

  always_comb
  begin
    case (tst)
      FRR_T_NONE:
      begin
        if (fwd_abort)
          next_tst = FRR_T_ABORT;
        else if (acc_flag && fwd && sent)
          next_tst = FRR_T_CRC0;
        else
          next_tst = FRR_T_NONE;
      end
      FRR_T_CRC0: next_tst = FRR_T_CRC1;
      FRR_T_CRC1: next_tst = FRR_T_CRC2;
      FRR_T_CRC2: next_tst = FRR_T_CRC3;
      FRR_T_CRC3: next_tst = FRR_T_FLAG;
      FRR_T_ABORT: next_tst = FRR_T_AFLAG;
      default: next_tst = FRR_T_NONE;
    endcase
  end

  always_comb
  begin
    next_out_valid = 1'b1;
    next_out_char = '{kind: FRR_K_DATA, data: 8'h00};
    case (tst)
      FRR_T_CRC0: next_out_char.data = ~tx_crc[31:24];
      FRR_T_CRC1: next_out_char.data = ~tx_crc[23:16];
      FRR_T_CRC2: next_out_char.data = ~tx_crc[15:8];
      FRR_T_CRC3: next_out_char.data = ~tx_crc[7:0];
      FRR_T_FLAG: next_out_char.kind = FRR_K_FLAG;
      FRR_T_AFLAG: next_out_char.kind = FRR_K_FLAG;
      FRR_T_ABORT: next_out_char.kind = FRR_K_ABORT;
      default:
      begin
        next_out_valid = pop && fwd && go;
        next_out_char.data = dl_data[0];
      end
    endcase
  end

  // Input stalls during the trailer and while a frame waits for the outbound port
  assign next_in_ready = (next_tst == FRR_T_NONE) &&
                         !(fwd && !(go || start_go) && next_cnt == `FRR_CRC_BYTES && pst != FRR_P_DISCARD);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst <= FRR_T_NONE;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_char <= '{kind: FRR_K_DATA, data: 8'h00};
    end
    else
    begin
      tst <= next_tst;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      out_char <= next_out_char;
    end
  end

  frr_crc32 u_rx_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .preset(acc_flag),
    .step(acc_data),
    .din(d),
    .crc(rx_crc)
  );

  frr_crc32 u_tx_crc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .preset(start_go),
    .step(pop && fwd && go),
    .din(dl_data[0]),
    .crc(tx_crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local delivery and error report
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loc_valid <= 1'b0;
      loc_data <= 8'h00;
      loc_ok <= 1'b0;
      loc_hdr <= '0;
      erp_req <= 1'b0;
      erp_code <= FRR_ERP_NONE;
    end
    else
    begin
      loc_valid <= pop && local_acc && dl_tag[0];
      loc_data <= dl_data[0];
      loc_ok <= 1'b0;
      erp_req <= 1'b0;
      if (end_frame && !in_aborted)
      begin
        if (!crc_good)
        begin
          erp_req <= 1'b1;
          erp_code <= FRR_ERP_CRC;
        end
        else if (!fwd && loc_reject)
        begin
          erp_req <= 1'b1;
          erp_code <= FRR_ERP_REJECT;
        end
        else if (local_acc)
        begin
          loc_ok <= 1'b1;
          loc_hdr.frame_type <= ftype;
          loc_hdr.sub_type <= sub;
          loc_hdr.status <= status;
          loc_hdr.channel <= chan_num;
          loc_hdr.ctl_msg <= (ftype != `FRR_TYPE_CTRL) && (chan_num == 14'h0000);
          loc_hdr.data_len <= data_len;
          loc_hdr.len_aligned <= (data_len & `FRR_ALIGN_MASK) == 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_CRC_TRAILER: assert property (
    (acc_flag && fwd && sent && crc_good) |-> ##2
    (out_valid && out_char.kind == FRR_K_DATA && out_char.data == ~tx_crc[31:24]) ##1
    (out_valid && out_char.kind == FRR_K_DATA)[*3] ##1 (out_valid && out_char.kind == FRR_K_FLAG))
    else $error("regenerated CRC trailer missing after inbound FLAG");
  AST_ABORT_BAD: assert property (
    (acc_flag && fwd && sent && !crc_good) |-> ##2
    (out_valid && out_char.kind == FRR_K_ABORT) ##1 (out_valid && out_char.kind == FRR_K_FLAG))
    else $error("bad forwarded frame not ended with ABORT and FLAG");
  AST_CRC_REPORT: assert property (
    (end_frame && !in_aborted && !crc_good) |=> (erp_req && erp_code == FRR_ERP_CRC && !loc_ok))
    else $error("CRC error not reported");
  AST_FIELDS_AFTER_CRC: assert property (
    loc_ok |-> ($past(crc_good) && $past(acc_flag)))
    else $error("local frame released without good CRC");
  AST_PATH_REJECT: assert property (
    (acc_data && pst == FRR_P_PATH && path_first && d == `FRR_ADDR_BAD) |=> (rej && !fwd && !local_acc))
    else $error("invalid first path byte not rejected");
  AST_PATH_DECREMENT: assert property (
    (acc_data && pst == FRR_P_PATH && path_first && d[`FRR_IDX_HI:0] != 7'h00) |=>
    (fwd && dl_data[3] == {$past(d[`FRR_EXT_BIT]), $past(d[`FRR_IDX_HI:0]) - 7'h01}))
    else $error("forwarded path byte not decremented");
  AST_HOLD_BUSY: assert property (
    (fwd && !go && dl_cnt == `FRR_CRC_BYTES && pst != FRR_P_DISCARD) |-> !in_ready)
    else $error("input taken while forwarding start is held");
  AST_DATA_LIMIT: assert property (
    loc_ok |-> (loc_hdr.data_len <= `FRR_DATA_MAX))
    else $error("local frame data field over limit");
  AST_CMSG_LIMIT: assert property (
    (loc_ok && loc_hdr.ctl_msg) |-> (loc_hdr.data_len <= `FRR_CMSG_MAX && loc_hdr.channel == 14'h0000))
    else $error("control message over limit or off channel zero");

endmodule
`default_nettype wire

/* File: frr_node_model.sv */
`default_nettype none
module frr_node_model
(
  input wire logic clk_sys, // Character clock
  input wire logic in_ready, // Router takes the offered character
  output logic in_valid, // Character offered
  output frr_pkg::frr_char_s in_char // Offered character
);
  timeunit 1ns;
  timeprecision 1ps;
  import frr_pkg::*;

  frr_char_s q[$];

  initial
  begin
    in_valid = 1'b0;
    in_char = '0;
  end

  // Offer holds until taken; an idle line shows no stale character
  always @(posedge clk_sys)
  begin
    if (in_valid && in_ready)
      void'(q.pop_front());
    #1;
    in_valid <= (q.size() != 0);
    if (q.size() != 0)
      in_char <= q[0];
    else
      in_char.data <= ~in_char.data;
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import frr_pkg::*;

  localparam logic [37:0] M_APP = 38'h3F00FFFFFF;
  localparam logic [37:0] M_RST = 38'h3FFF000000;
  localparam logic [37:0] M_ERP = 38'h3000000000;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic in_valid, in_ready, out_busy, ready_wait_flag, out_valid, loc_valid, loc_ok, erp_req;
  frr_char_s in_char, out_char;
  logic [7:0] loc_data;
  frr_hdr_s loc_hdr;
  frr_erp_e erp_code;
  frr_char_s eo[$];
  logic [7:0] el[$];
  logic [37:0] ee[$], em[$];
  int n_fail = 0;
  int checks = 0;

  always #25 clk_sys = ~clk_sys;

  frr_node_model frr_node_model_i (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid), .in_char(in_char));

  frr_router frr_router_i (.clk_sys(clk_sys), .rstn(rstn), .in_valid(in_valid), .in_char(in_char),
    .in_ready(in_ready), .out_busy(out_busy), .ready_wait_flag(ready_wait_flag), .out_valid(out_valid),
    .out_char(out_char), .loc_valid(loc_valid), .loc_data(loc_data), .loc_ok(loc_ok), .loc_hdr(loc_hdr),
    .erp_req(erp_req), .erp_code(erp_code));

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bad_line(input logic [37:0] g, input logic [37:0] e);
    n_fail++;
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
  endtask

  task automatic cmp_out(input frr_char_s g);
    frr_char_s e;
    checks++;
    e = (eo.size() != 0) ? eo.pop_front() : frr_char_s'(10'h3FF);
    if (e.kind === FRR_K_DATA ? g !== e : g.kind !== e.kind)
      bad_line({28'h0, g}, {28'h0, e});
  endtask

  task automatic cmp_loc(input logic [7:0] g);
    logic [7:0] e;
    checks++;
    e = (el.size() != 0) ? el.pop_front() : 8'hXX;
    if (g !== e)
      bad_line({30'h0, g}, {30'h0, e});
  endtask

  task automatic cmp_evt(input logic [37:0] g);
    logic [37:0] e, m;
    checks++;
    e = (ee.size() != 0) ? ee.pop_front() : 38'h3FFFFFFFFF;
    m = (em.size() != 0) ? em.pop_front() : 38'h3FFFFFFFFF;
    if ((g & m) !== e)
      bad_line(g & m, e);
  endtask

  // Output watcher
  always @(posedge clk_sys)
  begin
    if (out_valid === 1'b1)
      cmp_out(out_char);
    if (loc_valid === 1'b1)
      cmp_loc(loc_data);
    if (loc_ok === 1'b1 || erp_req === 1'b1)
      cmp_evt({erp_req ? 2'(erp_code) : 2'h0, loc_hdr});
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i][k]) ? 32'h04C11DB7 : 32'h0);
    return c;
  endfunction

  task automatic send(input logic [7:0] b[$], input logic bad, input int sp);
    logic [31:0] c;
    c = ~crc_of(b) ^ {31'h0, bad};
    foreach (b[i])
    begin
      if (i == sp)
        frr_node_model_i.q.push_back(frr_char_s'{FRR_K_SPECIAL, 8'h5A});
      frr_node_model_i.q.push_back(frr_char_s'{FRR_K_DATA, b[i]});
    end
    for (int k = 3; k >= 0; k--)
      frr_node_model_i.q.push_back(frr_char_s'{FRR_K_DATA, c[k*8 +: 8]});
    frr_node_model_i.q.push_back(frr_char_s'{FRR_K_FLAG, 8'h00});
  endtask

  task automatic exp_ev(input logic [37:0] v, input logic [37:0] m);
    ee.push_back(v);
    em.push_back(m);
  endtask

  task automatic fwd_frame(input logic [7:0] b[$], input logic bad);
    logic [31:0] c;
    send(b, bad, -1);
    b[1] = b[1] - 8'h01;
    c = ~crc_of(b);
    foreach (b[i])
      eo.push_back(frr_char_s'{FRR_K_DATA, b[i]});
    if (bad)
    begin
      eo.push_back(frr_char_s'{FRR_K_ABORT, 8'h00});
      exp_ev({FRR_ERP_CRC, 36'h0}, M_ERP);
    end
    else
      for (int k = 3; k >= 0; k--)
        eo.push_back(frr_char_s'{FRR_K_DATA, c[k*8 +: 8]});
    eo.push_back(frr_char_s'{FRR_K_FLAG, 8'h00});
  endtask

  task automatic local_frame(input logic [7:0] ctl, c1, c2, input int n, input logic bad, input int sp);
    logic [7:0] b[$];
    logic [13:0] ch;
    b = {ctl, 8'h00, c1};
    if (c1[7])
      b.push_back(c2);
    ch = c1[7] ? {c1[6:0], c2[6:0]} : {7'h0, c1[6:0]};
    repeat (n)
    begin
      b.push_back(8'($urandom()));
      el.push_back(b[$]);
    end
    send(b, bad, sp);
    if (bad)
      exp_ev({FRR_ERP_CRC, 36'h0}, M_ERP);
    else
      exp_ev({2'h0, ctl[3:2], ctl[1:0], 8'h00, ch, ch == 14'h0, 8'(n), n % 8 == 0}, M_APP);
  endtask

  task automatic drain();
    int t;
    t = 0;
    while ((eo.size() + el.size() + ee.size() + frr_node_model_i.q.size()) != 0 && t < 3000)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 3000)
    begin
      bad_line(38'h0, 38'h1);
      report_and_stop();
    end
    repeat (8) @(posedge clk_sys);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] b[$];
    logic [7:0] st;
    out_busy = 1'b0;
    ready_wait_flag = 1'b0;
    void'($urandom(32'hAB84));
    repeat (3) @(posedge clk_sys);
    #1 rstn = 1'b1;
    frr_node_model_i.q.push_back(frr_char_s'{FRR_K_FLAG, 8'h00});
    local_frame(8'h01, 8'h00, 8'h00, 1, 1'b0, 3);
    local_frame(8'h82, 8'h81, 8'h03, 16, 1'b0, -1);
    local_frame(8'h03, 8'h01, 8'h00, 128, 1'b0, -1);
    local_frame(8'h00, 8'h00, 8'h00, 32, 1'b0, -1);
    local_frame(8'h01, 8'h05, 8'h00, 3, 1'b1, -1);
    drain();
    st = 8'($urandom());
    send({8'h0C, st}, 1'b0, -1);
    exp_ev({2'h0, 2'h3, 2'h0, st, 24'h0}, M_RST);
    send({8'h00, 8'h80, 8'h00}, 1'b0, -1);
    exp_ev({FRR_ERP_REJECT, 36'h0}, M_ERP);
    drain();
    for (int m = 0; m < 4; m++)
    begin
      b = {8'h81, 8'h02, 8'h05};
      repeat ($urandom_range(0, 20))
        b.push_back(8'($urandom()));
      #1 out_busy = (m == 1);
      ready_wait_flag = (m == 2);
      fwd_frame(b, m == 3);
      repeat (40) @(posedge clk_sys);
      #1 out_busy = 1'b0;
      ready_wait_flag = 1'b0;
      drain();
    end
    // Inbound abort in mid-forward: five characters out, then ABORT and FLAG, no recovery request
    b = {8'h81, 8'h03, 8'h05, 8'($urandom()), 8'($urandom()), 8'h33, 8'h44, 8'h55, 8'h66};
    foreach (b[i])
      frr_node_model_i.q.push_back(frr_char_s'{FRR_K_DATA, b[i]});
    frr_node_model_i.q.push_back(frr_char_s'{FRR_K_ABORT, 8'h00});
    frr_node_model_i.q.push_back(frr_char_s'{FRR_K_FLAG, 8'h00});
    b[1] = 8'h02;
    for (int i = 0; i < 5; i++)
      eo.push_back(frr_char_s'{FRR_K_DATA, b[i]});
    eo.push_back(frr_char_s'{FRR_K_ABORT, 8'h00});
    eo.push_back(frr_char_s'{FRR_K_FLAG, 8'h00});
    drain();
    report_and_stop();
  end
endmodule
`default_nettype wire
